// ---- verilog/fpt_top.sv ----
// Flash program/erase timing sequencer with reload and auto-read registers
`timescale 1ns/1ps
module fpt_top
  import fpt_pkg::*;
(
  // Clock and reset
  input  wire logic             clk_sys_in,
  input  wire logic             sys_rst_in,
  // Register port
  input  wire logic [3:0]       reg_idx_in,
  input  wire logic             reg_wr_in,
  input  wire logic [15:0]      reg_wdata_in,
  output logic [15:0]           reg_rdata_out,
  // Processor requests
  input  wire logic             req_valid_in,
  input  wire fpt_pkg::fpt_cmd_e req_kind_in,
  input  wire logic             prog_ready_irq_en_in,
  output logic                  prog_buffer_full_out,
  output logic                  data_loss_error_out,
  output logic                  flash_busy_flag_out,
  output logic                  cpu_stall_out,
  output logic                  prog_ready_irq_out,
  // Flash array
  input  wire logic [15:0]      info0_word_in,
  input  wire logic [15:0]      info1_word_in,
  output logic                  flash_pulse_out,
  output fpt_pkg::fpt_cmd_e     flash_pulse_kind_out,
  // Auto-read functions
  input  wire logic             usb_ctrl_lowpower_in,
  output logic                  usb_xcvr_lowpower_out,
  output logic [15:0]           code_start_address_out
);
  typedef struct packed {
    logic [NUM_TIMING-1:0][7:0] tim;
    fpt_state_e                 st;
    logic                       buf_full;
    fpt_cmd_e                   buf_kind;
    fpt_cmd_e                   cur_kind;
    logic                       data_loss_error;
    logic                       busy;
    logic                       latched;
    logic [15:0]                fw;
    logic [15:0]                pw;
    logic [15:0]                csa;
    logic [15:0]                rdata;
    logic                       stall;
    logic                       irq;
    logic                       pulse;
    logic                       usb_lp;
  } fpt_top_s;

  localparam fpt_top_s TOP_RST = '{
    tim: TIMING_RST, st: FPT_IDLE, buf_full: 1'b0, buf_kind: FPT_CMD_PROG,
    cur_kind: FPT_CMD_PROG, data_loss_error: 1'b0, busy: 1'b0, latched: 1'b0, fw: 16'h0000,
    pw: 16'h0000, csa: 16'h0000, rdata: 16'h0000, stall: 1'b0, irq: 1'b0,
    pulse: 1'b0, usb_lp: 1'b1};

  fpt_top_s                q_reg, q_next;
  logic                    ld;
  logic [PHASE_CNT_W-1:0]  ldv;
  logic                    tick;
  fpt_phase_if             ph();

  fpt_prescaler #(
    .DIV_W      (PRESC_DIV_W)
  ) u_presc (
    .clk_sys_in (clk_sys_in),
    .sys_rst_in (sys_rst_in),
    .divisor_in (q_reg.tim[IDX_PRESCALER][PRESC_DIV_W-1:0]),
    .tick_out   (tick)
  );

  fpt_phase_cnt #(
    .CNT_W      (PHASE_CNT_W)
  ) u_cnt (
    .clk_sys_in (clk_sys_in),
    .sys_rst_in (sys_rst_in),
    .ph         (ph)
  );

  assign ph.load  = ld;
  assign ph.value = ldv;
  assign ph.tick  = tick;

  always_comb begin
    q_next = q_reg;
    ld = 1'b0;
    ldv = '0;
    q_next.irq = 1'b0;
    // Straps are caught on the first clocked cycle after release, not by the reset itself
    if (!q_reg.latched) begin
      q_next.latched = 1'b1;
      q_next.fw = info0_word_in;
      q_next.pw = info1_word_in;
      q_next.csa = {1'b0, ~info1_word_in[BOOT_MSB:BOOT_LSB], 11'h000};
    end
    q_next.usb_lp = q_reg.fw[FW_USB_EN_BIT] ? usb_ctrl_lowpower_in : 1'b1;
    // Busy timing writes are honoured; software is trusted not to make them
    if (reg_wr_in) begin
      case (reg_idx_in)
        IDX_PRESCALER: q_next.tim[IDX_PRESCALER] = reg_wdata_in[7:0] & PRESC_MASK;
        IDX_START, IDX_TRANSITION, IDX_PROGRAM, IDX_PAGE_ERASE, IDX_MOD_ERASE,
        IDX_END, IDX_MOD_END, IDX_RECOVERY: q_next.tim[reg_idx_in] = reg_wdata_in[7:0];
        IDX_STATUS: begin
          if (reg_wdata_in[ST_DATA_LOSS_ERROR]) begin
            q_next.data_loss_error = 1'b0;
          end
        end
        default: ;
      endcase
    end
    // Overrun set comes after the clear so it wins in a shared cycle
    if (req_valid_in) begin
      if (q_reg.buf_full) begin
        q_next.data_loss_error = 1'b1;
      end else begin
        q_next.buf_full = 1'b1;
        q_next.buf_kind = req_kind_in;
      end
    end
    q_next.stall = q_reg.busy && req_valid_in;
    case (q_reg.st)
      FPT_IDLE: begin
        if (q_reg.buf_full) begin
          q_next.buf_full = 1'b0;
          q_next.cur_kind = q_reg.buf_kind;
          q_next.irq = prog_ready_irq_en_in;
          q_next.st = FPT_START;
          ld = 1'b1;
          ldv = fpt_len(q_reg.tim[IDX_START], SHIFT_ONE);
        end
      end
      FPT_START: begin
        if (ph.done) begin
          q_next.st = FPT_TRAN1;
          ld = 1'b1;
          ldv = fpt_len(q_reg.tim[IDX_TRANSITION], SHIFT_ONE);
        end
      end
      FPT_TRAN1: begin
        if (ph.done) begin
          q_next.st = FPT_PULSE;
          q_next.pulse = 1'b1;
          ld = 1'b1;
          case (q_reg.cur_kind)
            FPT_CMD_PAGE: ldv = fpt_len(q_reg.tim[IDX_PAGE_ERASE], SHIFT_4096);
            FPT_CMD_MODULE: ldv = fpt_len(q_reg.tim[IDX_MOD_ERASE], SHIFT_4096);
            default: ldv = fpt_len(q_reg.tim[IDX_PROGRAM], SHIFT_EIGHT);
          endcase
        end
      end
      FPT_PULSE: begin
        if (ph.done) begin
          q_next.st = FPT_TRAN2;
          q_next.pulse = 1'b0;
          ld = 1'b1;
          ldv = fpt_len(q_reg.tim[IDX_TRANSITION], SHIFT_ONE);
        end
      end
      FPT_TRAN2: begin
        if (ph.done) begin
          ld = 1'b1;
          if (q_reg.cur_kind == FPT_CMD_MODULE) begin
            q_next.st = FPT_MEND;
            ldv = fpt_len(q_reg.tim[IDX_MOD_END], SHIFT_EIGHT);
          end else begin
            q_next.st = FPT_END;
            ldv = fpt_len(q_reg.tim[IDX_END], SHIFT_ONE);
          end
        end
      end
      FPT_END, FPT_MEND: begin
        if (ph.done) begin
          q_next.st = FPT_RCV;
          ld = 1'b1;
          ldv = fpt_len(q_reg.tim[IDX_RECOVERY], SHIFT_ONE);
        end
      end
      FPT_RCV: begin
        if (ph.done) begin
          q_next.st = FPT_IDLE;
        end
      end
      default: q_next.st = FPT_IDLE;
    endcase
    q_next.busy = (q_next.st != FPT_IDLE);
    case (reg_idx_in)
      IDX_FUNC, IDX_FUNC_MIR: q_next.rdata = q_reg.fw;
      IDX_PROT, IDX_PROT_MIR: q_next.rdata = q_reg.pw;
      IDX_CSTART, IDX_CSTART_MIR: q_next.rdata = q_reg.csa;
      IDX_STATUS: begin
        q_next.rdata = '0;
        q_next.rdata[ST_DATA_LOSS_ERROR] = q_reg.data_loss_error;
        q_next.rdata[ST_FULL] = q_reg.buf_full;
        q_next.rdata[ST_BUSY] = q_reg.busy;
      end
      default: q_next.rdata = {8'h00, q_reg.tim[reg_idx_in]};
    endcase
  end

  always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      q_reg <= TOP_RST;
    end else begin
      q_reg <= q_next;
    end
  end

  assign reg_rdata_out          = q_reg.rdata;
  assign prog_buffer_full_out   = q_reg.buf_full;
  assign data_loss_error_out    = q_reg.data_loss_error;
  assign flash_busy_flag_out    = q_reg.busy;
  assign cpu_stall_out          = q_reg.stall;
  assign prog_ready_irq_out     = q_reg.irq;
  assign flash_pulse_out        = q_reg.pulse;
  assign flash_pulse_kind_out   = q_reg.cur_kind;
  assign usb_xcvr_lowpower_out  = q_reg.usb_lp;
  assign code_start_address_out = q_reg.csa;

  // Checks
  property p_full_refuses;
    @(posedge clk_sys_in) disable iff (sys_rst_in)
      q_reg.buf_full && req_valid_in && q_reg.st != FPT_IDLE
      |=> q_reg.buf_full && q_reg.buf_kind == $past(q_reg.buf_kind);
  endproperty
  a_full_refuses: assert property (p_full_refuses)
    else $error("full buffer accepted a request");

  property p_ready_irq;
    @(posedge clk_sys_in) disable iff (sys_rst_in)
      q_reg.st == FPT_IDLE && q_reg.buf_full && prog_ready_irq_en_in
      |=> prog_ready_irq_out && !prog_buffer_full_out ##1 !prog_ready_irq_out;
  endproperty
  a_ready_irq: assert property (p_ready_irq)
    else $error("ready interrupt missing or not a single pulse");

  property p_overrun;
    @(posedge clk_sys_in) disable iff (sys_rst_in)
      q_reg.buf_full && req_valid_in |=> data_loss_error_out;
  endproperty
  a_overrun: assert property (p_overrun)
    else $error("overrun did not set data loss flag");

  property p_data_loss_error_w0;
    @(posedge clk_sys_in) disable iff (sys_rst_in)
      q_reg.data_loss_error && reg_wr_in && reg_idx_in == IDX_STATUS && !reg_wdata_in[ST_DATA_LOSS_ERROR]
      |=> data_loss_error_out;
  endproperty
  a_data_loss_error_w0: assert property (p_data_loss_error_w0)
    else $error("writing 0 changed data loss flag");

  property p_data_loss_error_w1;
    @(posedge clk_sys_in) disable iff (sys_rst_in)
      reg_wr_in && reg_idx_in == IDX_STATUS && reg_wdata_in[ST_DATA_LOSS_ERROR]
      && !(req_valid_in && q_reg.buf_full) |=> !data_loss_error_out;
  endproperty
  a_data_loss_error_w1: assert property (p_data_loss_error_w1)
    else $error("writing 1 did not clear data loss flag");

  property p_start_len;
    @(posedge clk_sys_in) disable iff (sys_rst_in)
      ld && q_next.st == FPT_START |-> ldv == {13'h0000, q_reg.tim[IDX_START]} + 21'h1;
  endproperty
  a_start_len: assert property (p_start_len)
    else $error("start phase length wrong");

  property p_prog_len;
    @(posedge clk_sys_in) disable iff (sys_rst_in)
      ld && q_next.st == FPT_PULSE && q_reg.cur_kind == FPT_CMD_PROG
      |-> ldv == ({13'h0000, q_reg.tim[IDX_PROGRAM]} + 21'h1) * 21'h8;
  endproperty
  a_prog_len: assert property (p_prog_len)
    else $error("program pulse length wrong");

  property p_merase_len;
    @(posedge clk_sys_in) disable iff (sys_rst_in)
      ld && q_next.st == FPT_PULSE && q_reg.cur_kind == FPT_CMD_MODULE
      |-> ldv == ({13'h0000, q_reg.tim[IDX_MOD_ERASE]} + 21'h1) * 21'h1000;
  endproperty
  a_merase_len: assert property (p_merase_len)
    else $error("module erase pulse length wrong");

  property p_page_len;
    @(posedge clk_sys_in) disable iff (sys_rst_in)
      ld && q_next.st == FPT_PULSE && q_reg.cur_kind == FPT_CMD_PAGE
      |-> ldv == ({13'h0000, q_reg.tim[IDX_PAGE_ERASE]} + 21'h1) * 21'h1000;
  endproperty
  a_page_len: assert property (p_page_len)
    else $error("page erase pulse length wrong");

  property p_mend_len;
    @(posedge clk_sys_in) disable iff (sys_rst_in)
      ld && q_next.st == FPT_MEND
      |-> ldv == ({13'h0000, q_reg.tim[IDX_MOD_END]} + 21'h1) * 21'h8;
  endproperty
  a_mend_len: assert property (p_mend_len)
    else $error("module end delay length wrong");

  property p_cstart;
    @(posedge clk_sys_in) disable iff (sys_rst_in)
      q_reg.latched |-> code_start_address_out[10:0] == 11'h000
      && !code_start_address_out[15]
      && code_start_address_out[14:11] == ~q_reg.pw[BOOT_MSB:BOOT_LSB];
  endproperty
  a_cstart: assert property (p_cstart)
    else $error("code start address malformed");

  property p_stall;
    @(posedge clk_sys_in) disable iff (sys_rst_in)
      flash_busy_flag_out && req_valid_in |=> cpu_stall_out;
  endproperty
  a_stall: assert property (p_stall)
    else $error("busy request did not stall");

  property p_usb_lp;
    @(posedge clk_sys_in) disable iff (sys_rst_in)
      q_reg.latched && !q_reg.fw[FW_USB_EN_BIT] |=> usb_xcvr_lowpower_out;
  endproperty
  a_usb_lp: assert property (p_usb_lp)
    else $error("transceiver not forced to low power");

  c_prog_pulse: cover property (@(posedge clk_sys_in) disable iff (sys_rst_in)
    flash_pulse_out && flash_pulse_kind_out == FPT_CMD_PROG);
  c_mod_end: cover property (@(posedge clk_sys_in) disable iff (sys_rst_in)
    q_reg.st == FPT_MEND && ph.done);
  c_overrun: cover property (@(posedge clk_sys_in) disable iff (sys_rst_in)
    q_reg.buf_full && req_valid_in);
endmodule

// ---- verilog/fpt_pkg.sv ----
// Constants and types for the flash program/erase timing block
package fpt_pkg;
  localparam int unsigned NUM_TIMING  = 9;
  localparam int unsigned PHASE_CNT_W = 21;
  localparam int unsigned PRESC_DIV_W = 5;

  // Register indices on the register port
  localparam logic [3:0] IDX_PRESCALER  = 4'h0;
  localparam logic [3:0] IDX_START      = 4'h1;
  localparam logic [3:0] IDX_TRANSITION = 4'h2;
  localparam logic [3:0] IDX_PROGRAM    = 4'h3;
  localparam logic [3:0] IDX_PAGE_ERASE = 4'h4;
  localparam logic [3:0] IDX_MOD_ERASE  = 4'h5;
  localparam logic [3:0] IDX_END        = 4'h6;
  localparam logic [3:0] IDX_MOD_END    = 4'h7;
  localparam logic [3:0] IDX_RECOVERY   = 4'h8;
  localparam logic [3:0] IDX_FUNC       = 4'h9;
  localparam logic [3:0] IDX_PROT       = 4'ha;
  localparam logic [3:0] IDX_CSTART     = 4'hb;
  localparam logic [3:0] IDX_STATUS     = 4'hc;
  localparam logic [3:0] IDX_FUNC_MIR   = 4'hd;
  localparam logic [3:0] IDX_PROT_MIR   = 4'he;
  localparam logic [3:0] IDX_CSTART_MIR = 4'hf;

  // Reset values, index 0 in the low byte
  localparam logic [NUM_TIMING-1:0][7:0] TIMING_RST =
    {8'h04, 8'h3c, 8'h18, 8'hea, 8'h04, 8'h16, 8'h30, 8'h18, 8'h04};
  localparam logic [7:0] PRESC_MASK = 8'h1f;

  // Status field positions
  localparam int unsigned ST_DATA_LOSS_ERROR = 4;
  localparam int unsigned ST_FULL = 3;
  localparam int unsigned ST_BUSY = 2;

  // Pulse multipliers as shift counts
  localparam logic [4:0] SHIFT_ONE   = 5'h00;
  localparam logic [4:0] SHIFT_EIGHT = 5'h03;
  localparam logic [4:0] SHIFT_4096  = 5'h0c;

  // Auto-read field positions
  localparam int unsigned BOOT_LSB      = 1;
  localparam int unsigned BOOT_MSB      = 4;
  localparam int unsigned FW_USB_EN_BIT = 0;

  typedef enum logic [1:0] {FPT_CMD_PROG, FPT_CMD_PAGE, FPT_CMD_MODULE} fpt_cmd_e;
  typedef enum logic [2:0] {
    FPT_IDLE, FPT_START, FPT_TRAN1, FPT_PULSE, FPT_TRAN2, FPT_END, FPT_MEND, FPT_RCV
  } fpt_state_e;

  function automatic logic [PHASE_CNT_W-1:0] fpt_len(input logic [7:0] rl,
                                                     input logic [4:0] sh);
    fpt_len = ({13'h0000, rl} + 21'h000001) << sh;
  endfunction
endpackage

// ---- verilog/fpt_phase_if.sv ----
// Load/tick/done bundle between sequencer and phase counter
`timescale 1ns/1ps
interface fpt_phase_if;
  logic                           load;
  logic [fpt_pkg::PHASE_CNT_W-1:0] value;
  logic                           tick;
  logic                           done;
  modport seq (output load, output value, output tick, input done);
  modport cnt (input load, input value, input tick, output done);
endinterface

// ---- verilog/fpt_prescaler.sv ----
// System clock prescaler producing one-cycle ticks
`timescale 1ns/1ps
module fpt_prescaler #(
  parameter int unsigned DIV_W = 5
) (
  // Clock and reset
  input  wire logic             clk_sys_in,
  input  wire logic             sys_rst_in,
  // Divisor and tick
  input  wire logic [DIV_W-1:0] divisor_in,
  output logic                  tick_out
);
  typedef struct packed {
    logic [DIV_W-1:0] cnt;
    logic             tick;
  } fpt_presc_s;
  fpt_presc_s q_reg, q_next;

  if (DIV_W < 1 || DIV_W > 8) begin : g_chk
    $error("fpt_prescaler: DIV_W out of range");
  end

  always_comb begin
    q_next = q_reg;
    q_next.tick = (q_reg.cnt >= divisor_in);
    q_next.cnt = q_next.tick ? '0 : q_reg.cnt + 1'b1;
  end

  always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      q_reg <= '0;
    end else begin
      q_reg <= q_next;
    end
  end

  assign tick_out = q_reg.tick;
endmodule

// ---- verilog/fpt_phase_cnt.sv ----
// Phase down-counter advanced by prescaler ticks
`timescale 1ns/1ps
module fpt_phase_cnt #(
  parameter int unsigned CNT_W = 21
) (
  // Clock and reset
  input wire logic   clk_sys_in,
  input wire logic   sys_rst_in,
  // Sequencer side
  fpt_phase_if.cnt   ph
);
  typedef struct packed {
    logic [CNT_W-1:0] cnt;
  } fpt_cnt_s;
  fpt_cnt_s q_reg, q_next;

  if (CNT_W < fpt_pkg::PHASE_CNT_W) begin : g_chk
    $error("fpt_phase_cnt: CNT_W too small for longest pulse");
  end

  always_comb begin
    q_next = q_reg;
    if (ph.load) begin
      q_next.cnt = CNT_W'(ph.value);
    end else if (ph.tick && q_reg.cnt != '0) begin
      q_next.cnt = q_reg.cnt - 1'b1;
    end
  end

  always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      q_reg <= '0;
    end else begin
      q_reg <= q_next;
    end
  end

  // Last tick of the phase; load wins over a same-cycle tick, so that tick is not counted.
  // Done must not look at load: the sequencer raises load from done, which would close a loop.
  assign ph.done = ph.tick && (q_reg.cnt == CNT_W'(1));
endmodule

// ---- dv/fpt_flash_model.sv ----
// Flash array stand-in: supplies info words and records the pulse kind
`timescale 1ns/1ps
module fpt_flash_model
  import fpt_pkg::*;
(
  // Clock
  input  wire logic              clk_sys_in,
  // Word set select and pulse from the block
  input  wire logic              word_set_in,
  input  wire logic              flash_pulse_in,
  input  wire fpt_pkg::fpt_cmd_e flash_pulse_kind_in,
  // Info words and observed kind
  output logic [15:0]            info0_word_out,
  output logic [15:0]            info1_word_out,
  output fpt_pkg::fpt_cmd_e      seen_kind_out
);
  // Array words are static; set 0 keeps the transceiver enable bit low
  assign info0_word_out = word_set_in ? 16'ha5c3 : 16'h5a3c;
  assign info1_word_out = word_set_in ? 16'h3c4b : 16'h00b4;

  always_ff @(posedge clk_sys_in) begin
    if (flash_pulse_in) begin
      seen_kind_out <= flash_pulse_kind_in;
    end
  end
endmodule

// ---- dv/tb_top.sv ----
// Self-checking bench for the flash program/erase timing block
`timescale 1ns/1ps
module tb_top;
  import fpt_pkg::*;
  logic        clk_sys_in, sys_rst_in, reg_wr, req_valid, irq_en, usb_ctrl_lp, word_set;
  logic        full, dloss, busy, stall, irq, pulse, usb_lp;
  logic [3:0]  reg_idx;
  logic [15:0] reg_wdata, rdata, info0, info1, cstart;
  fpt_cmd_e    req_kind, pulse_kind, seen_kind;
  int          errors, n_compared, irq_cnt, bl, pl, base_b, bm;
  logic [7:0]  fast [0:8] = '{8'h00, 8'h02, 8'h02, 8'h00, 8'h00, 8'h00, 8'h02, 8'h00, 8'h02};
  logic [3:0]  dl_idx [0:4] = '{IDX_START, IDX_TRANSITION, IDX_PROGRAM, IDX_END, IDX_RECOVERY};
  int          dl_b [0:4] = '{16, 32, 128, 16, 16};
  int          dl_p [0:4] = '{0, 0, 128, 0, 0};

  fpt_top u_dut (.clk_sys_in(clk_sys_in), .sys_rst_in(sys_rst_in), .reg_idx_in(reg_idx),
    .reg_wr_in(reg_wr), .reg_wdata_in(reg_wdata), .reg_rdata_out(rdata),
    .req_valid_in(req_valid), .req_kind_in(req_kind), .prog_ready_irq_en_in(irq_en),
    .prog_buffer_full_out(full), .data_loss_error_out(dloss), .flash_busy_flag_out(busy),
    .cpu_stall_out(stall), .prog_ready_irq_out(irq), .info0_word_in(info0),
    .info1_word_in(info1), .flash_pulse_out(pulse), .flash_pulse_kind_out(pulse_kind),
    .usb_ctrl_lowpower_in(usb_ctrl_lp), .usb_xcvr_lowpower_out(usb_lp),
    .code_start_address_out(cstart));
  fpt_flash_model u_flash (.clk_sys_in(clk_sys_in), .word_set_in(word_set),
    .flash_pulse_in(pulse), .flash_pulse_kind_in(pulse_kind), .info0_word_out(info0),
    .info1_word_out(info1), .seen_kind_out(seen_kind));

  initial begin
    clk_sys_in = 1'b0;
    forever #20 clk_sys_in = ~clk_sys_in;
  end

  always @(posedge clk_sys_in) begin
    if (irq === 1'b1) irq_cnt++;
  end

  task automatic give_verdict();
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic check_eq(input logic [15:0] got, input logic [15:0] exp, input string what);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("ERROR t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic check_rng(input int got, input int lo, input int hi, input string what);
    n_compared++;
    if (got < lo || got > hi) begin
      errors++;
      $display("ERROR t=%0t %s got %0d exp %0d..%0d", $time, what, got, lo, hi);
    end
  endtask

  task automatic reg_write(input logic [3:0] idx, input logic [15:0] d);
    @(posedge clk_sys_in);
    reg_idx <= idx;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys_in);
    reg_wr <= 1'b0;
  endtask

  task automatic rd_chk(input logic [3:0] idx, input logic [15:0] exp, input string what);
    @(posedge clk_sys_in);
    reg_idx <= idx;
    @(posedge clk_sys_in);
    #1 check_eq(rdata, exp, what);
  endtask

  // Ends just after the edge that takes the request, so flags are settled
  task automatic pulse_req(input fpt_cmd_e k);
    @(posedge clk_sys_in);
    req_valid <= 1'b1;
    req_kind <= k;
    @(posedge clk_sys_in);
    req_valid <= 1'b0;
    #1;
  endtask

  task automatic wait_busy();
    for (int i = 0; i < 5 && busy !== 1'b1; i++) begin
      @(posedge clk_sys_in);
      #1;
    end
  endtask

  // Busy and pulse lengths in system clocks for one operation
  task automatic do_op(input fpt_cmd_e k);
    pulse_req(k);
    wait_busy();
    bl = 0;
    pl = 0;
    while (busy === 1'b1 && bl < 20000) begin
      bl++;
      if (pulse === 1'b1) pl++;
      @(posedge clk_sys_in);
      #1;
    end
  endtask

  task automatic wait_idle();
    int quiet;
    quiet = 0;
    for (int i = 0; i < 20000 && quiet < 3; i++) begin
      @(posedge clk_sys_in);
      #1 quiet = (busy === 1'b0 && full === 1'b0) ? quiet + 1 : 0;
    end
  endtask

  task automatic do_reset(input logic ws);
    @(posedge clk_sys_in);
    sys_rst_in <= 1'b1;
    word_set <= ws;
    repeat (3) @(posedge clk_sys_in);
    sys_rst_in <= 1'b0;
    repeat (2) @(posedge clk_sys_in);
    #1;
  endtask

  task automatic usb_chk(input logic ctrl, input logic exp);
    @(posedge clk_sys_in);
    usb_ctrl_lp <= ctrl;
    repeat (2) @(posedge clk_sys_in);
    #1 check_eq({15'h0000, usb_lp}, {15'h0000, exp}, "xcvr low power");
  endtask

  task automatic autoread_chk();
    logic [15:0] cs;
    cs = {1'b0, ~info1[BOOT_MSB:BOOT_LSB], 11'h000};
    reg_write(IDX_FUNC, ~info0);
    reg_write(IDX_CSTART, 16'hffff);
    rd_chk(IDX_FUNC, info0, "function word");
    rd_chk(IDX_FUNC_MIR, info0, "function mirror");
    rd_chk(IDX_PROT, info1, "protection word");
    rd_chk(IDX_PROT_MIR, info1, "protection mirror");
    rd_chk(IDX_CSTART, cs, "code start");
    rd_chk(IDX_CSTART_MIR, cs, "code start mirror");
    check_eq(cstart, cs, "code start port");
  endtask

  initial begin
    repeat (60000) @(posedge clk_sys_in);
    errors++;
    $display("ERROR t=%0t watchdog expired", $time);
    give_verdict();
  end

  initial begin
    errors = 0;
    n_compared = 0;
    irq_cnt = 0;
    sys_rst_in = 1'b1;
    reg_idx = 4'h0;
    reg_wr = 1'b0;
    reg_wdata = 16'h0000;
    req_valid = 1'b0;
    req_kind = FPT_CMD_PROG;
    irq_en = 1'b1;
    usb_ctrl_lp = 1'b0;
    word_set = 1'b0;
    do_reset(1'b0);
    for (int i = 0; i < 9; i++) begin
      rd_chk(i[3:0], {8'h00, TIMING_RST[i]}, "reset value");
    end
    rd_chk(IDX_STATUS, 16'h0000, "status at reset");
    autoread_chk();
    usb_chk(1'b0, 1'b1);
    reg_write(IDX_PRESCALER, 16'h00ff);
    rd_chk(IDX_PRESCALER, 16'h001f, "divisor width");
    $display("test registers done");
    // Short reloads keep every phase measurable; writes only while idle
    for (int i = 0; i < 9; i++) reg_write(i[3:0], {8'h00, fast[i]});
    do_op(FPT_CMD_PROG);
    base_b = bl;
    check_rng(pl, 8, 9, "program pulse");
    check_eq({14'h0000, seen_kind}, {14'h0000, FPT_CMD_PROG}, "pulse kind");
    for (int i = 0; i < 5; i++) begin
      reg_write(dl_idx[i], {8'h00, fast[dl_idx[i]] + 8'h10});
      do_op(FPT_CMD_PROG);
      reg_write(dl_idx[i], {8'h00, fast[dl_idx[i]]});
      check_rng(bl - base_b, dl_b[i], dl_b[i], "busy delta");
      check_rng(pl - 8, dl_p[i], dl_p[i] + 1, "pulse delta");
    end
    do_op(FPT_CMD_PAGE);
    check_rng(pl, 4096, 4097, "page pulse");
    check_rng(bl - base_b, 4088, 4088, "page busy");
    check_eq({14'h0000, seen_kind}, {14'h0000, FPT_CMD_PAGE}, "pulse kind");
    do_op(FPT_CMD_MODULE);
    bm = bl;
    check_rng(pl, 4096, 4097, "module pulse");
    check_rng(bm - base_b, 4093, 4093, "module busy");
    check_eq({14'h0000, seen_kind}, {14'h0000, FPT_CMD_MODULE}, "pulse kind");
    reg_write(IDX_MOD_END, 16'h0001);
    do_op(FPT_CMD_MODULE);
    check_rng(bl - bm, 8, 8, "module end delta");
    reg_write(IDX_PRESCALER, 16'h0001);
    do_op(FPT_CMD_PROG);
    check_rng(pl, 15, 17, "divided pulse");
    reg_write(IDX_PRESCALER, 16'h0000);
    $display("test timing done");
    irq_cnt = 0;
    pulse_req(FPT_CMD_PROG);
    wait_busy();
    pulse_req(FPT_CMD_PROG);
    check_eq({14'h0000, full, stall}, 16'h0003, "full and stall");
    check_eq({15'h0000, dloss}, 16'h0000, "no loss yet");
    pulse_req(FPT_CMD_PAGE);
    check_eq({14'h0000, full, dloss}, 16'h0003, "overrun");
    wait_idle();
    check_rng(irq_cnt, 2, 2, "ready irqs");
    rd_chk(IDX_STATUS, 16'h0010, "status loss");
    reg_write(IDX_STATUS, 16'h0000);
    rd_chk(IDX_STATUS, 16'h0010, "write zero");
    reg_write(IDX_STATUS, 16'h0010);
    rd_chk(IDX_STATUS, 16'h0000, "write one");
    @(posedge clk_sys_in);
    irq_en <= 1'b0;
    do_op(FPT_CMD_PROG);
    check_rng(irq_cnt, 2, 2, "masked irq");
    $display("test buffer done");
    do_reset(1'b1);
    rd_chk(IDX_PRESCALER, 16'h0004, "prescaler reset");
    autoread_chk();
    usb_chk(1'b0, 1'b0);
    usb_chk(1'b1, 1'b1);
    $display("test auto-read done");
    give_verdict();
  end
endmodule
